//--- bench/mbe_master_model.sv
// Far-side model: serial master sending request bytes and taking reply bytes.
// Assumes baud_div of one; a byte every two clocks stays well inside the gap limit.
`timescale 1ns/1ps
module mbe_master_model
	import mbe_pkg::*;
(
	// Clock
	input wire logic clk,
	// Bytes toward the slave
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_err,
	// Bytes from the slave
	input wire logic tx_valid_q,
	input wire logic [7:0] tx_data_q,
	output logic tx_ready
);
	mbe_byte_t got[$];
	bit slow = 0;
	initial
	begin
		rx_valid = 0;
		rx_data = 8'hA5;
		rx_err = 0;
		tx_ready = 0;
	end
	function automatic logic [15:0] crc16(input mbe_byte_t f[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (f[i])
		begin
			c ^= {8'h00, f[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	// Idle data shows the inverse of the last byte so a stale value never matches
	task automatic send(input mbe_byte_t f[$], input int err_at, input int gap_at, input bit bad_crc);
		logic [15:0] c;
		c = crc16(f) ^ {15'h0000, bad_crc};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		foreach (f[i])
		begin
			if (i == gap_at)
				repeat (30) @(posedge clk);
			@(posedge clk);
			#1;
			rx_valid = 1;
			rx_data = f[i];
			rx_err = (i == err_at);
			@(posedge clk);
			#1;
			rx_valid = 0;
			rx_err = 0;
			rx_data = ~f[i];
		end
	endtask
	// Slow mode stalls every other cycle to exercise the reply hold
	always @(posedge clk)
	begin
		if (tx_valid_q && tx_ready)
			got.push_back(tx_data_q);
		#1;
		tx_ready = !slow || !tx_ready;
	end
	task automatic echo(input int cycles, input bit corrupt);
		mbe_byte_t b;
		repeat (cycles)
		begin
			@(posedge clk);
			if (tx_valid_q && tx_ready)
			begin
				b = tx_data_q ^ {8{corrupt}};
				#1;
				rx_valid = 1;
				rx_data = b;
				@(posedge clk);
				#1;
				rx_valid = 0;
				rx_data = ~b;
			end
			else
				#1;
		end
	endtask
endmodule // mbe_master_model

//--- bench/mbe_slave_assertions.sv
// Concurrent checks on the request checker's top ports.
// Assumes one clock domain and binding to mbe_slave.
`timescale 1ns/1ps
`include "mbe_defines.svh"
module mbe_slave_assertions
	import mbe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Watched signals
	input wire logic tx_valid_q,
	input wire logic [7:0] tx_data_q,
	input wire logic tx_ready,
	input wire logic param_busy,
	input wire logic bus_undervoltage_fault,
	input wire logic wr_en_q,
	input wire logic req_valid_q,
	input wire logic [7:0] req_func_q,
	input wire logic [15:0] req_start_q,
	input wire logic [15:0] req_qty_q,
	input wire logic req_reply_q,
	input wire logic [7:0] input_six_function_select,
	input wire logic selftest_pass_q,
	input wire logic comm_error_q
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	AST_TX_HOLD: assert property (
		tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q))
		else $error("reply byte withdrawn before taken");
	AST_TX_GAP: assert property (
		tx_valid_q && tx_ready |=> !tx_valid_q)
		else $error("reply byte not released after handshake");
	AST_WR_GUARD: assert property (
		wr_en_q |-> !param_busy && !bus_undervoltage_fault)
		else $error("write executed while writes are barred");
	AST_REQ_FUNC: assert property (
		req_valid_q |-> req_func_q inside {`MBE_FC_READ, `MBE_FC_LOOP, `MBE_FC_WRITE})
		else $error("unsupported function accepted");
	AST_QTY: assert property (
		req_valid_q && req_func_q != `MBE_FC_LOOP |-> req_qty_q inside {[16'h0001:16'h0010]})
		else $error("bad quantity accepted");
	AST_BCAST_REG: assert property (
		req_valid_q && !req_reply_q |-> req_func_q == `MBE_FC_WRITE && req_start_q != 16'h0000
		&& req_start_q + req_qty_q <= 16'h0003)
		else $error("broadcast outside its registers accepted");
	AST_BCAST_QUIET: assert property (
		req_valid_q && !req_reply_q |=> !tx_valid_q [*8])
		else $error("broadcast answered");
	AST_SELFTEST_OFF: assert property (
		(input_six_function_select != `MBE_SELFTEST_SEL) [*6] |-> !selftest_pass_q && !comm_error_q)
		else $error("self-test flag outside test mode");
endmodule // mbe_slave_assertions
bind mbe_slave mbe_slave_assertions chk (.clk(clk), .resetn(resetn), .tx_valid_q(tx_valid_q),
	.tx_data_q(tx_data_q), .tx_ready(tx_ready), .param_busy(param_busy),
	.bus_undervoltage_fault(bus_undervoltage_fault), .wr_en_q(wr_en_q), .req_valid_q(req_valid_q),
	.req_func_q(req_func_q), .req_start_q(req_start_q), .req_qty_q(req_qty_q), .req_reply_q(req_reply_q),
	.input_six_function_select(input_six_function_select), .selftest_pass_q(selftest_pass_q),
	.comm_error_q(comm_error_q));

//--- bench/mbe_slave_bench.sv
// Self-checking bench: exceptions, silent drops, writes, broadcasts and self-test.
// Assumes baud_div of one, so a frame closes 25 clocks after its last byte.
`timescale 1ns/1ps
module mbe_slave_bench
	import mbe_pkg::*;
;
	typedef mbe_byte_t mbe_frame_t[$];
	localparam mbe_byte_t STN = 8'h11;
	logic clk = 0;
	logic resetn = 0;
	logic running = 0, uv = 0, nv = 0, busy = 0, six = 0;
	logic [7:0] sel = 8'h00;
	logic rx_valid, rx_err, tx_ready, tx_valid_q, wr_en_q, req_valid_q, req_reply_q, pass_q, cerr_q, last_reply;
	logic [7:0] rx_data, tx_data_q, req_func_q, last_func;
	logic [15:0] last_start, last_qty, baud = 16'h0001;
	logic [15:0] query_reg_q, query_data_q, wr_reg_q, wr_data_q, req_start_q, req_qty_q, last_reg, last_data;
	int bad_count = 0, cmp_count = 0, wr_n = 0, req_n = 0, cyc = 0;
	always #25 clk = ~clk;
	mbe_master_model m (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
		.tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .tx_ready(tx_ready));
	mbe_slave dut (.clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
		.baud_div(baud), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .tx_ready(tx_ready),
		.station_address_setting(STN), .drive_running(running), .bus_undervoltage_fault(uv),
		.nonvolatile_data_fault(nv), .param_busy(busy), .query_reg_q(query_reg_q), .query_data_q(query_data_q),
		.reg_exists(query_reg_q != 16'h0BAD), .reg_read_only(query_reg_q == 16'h0020),
		.reg_run_locked(query_reg_q == 16'h0030), .reg_init_exempt(query_reg_q == 16'h0040),
		.data_in_range(query_data_q < 16'h1000), .data_consistent(query_data_q != 16'h0777),
		.wr_en_q(wr_en_q), .wr_reg_q(wr_reg_q), .wr_data_q(wr_data_q), .req_valid_q(req_valid_q),
		.req_func_q(req_func_q), .req_start_q(req_start_q), .req_qty_q(req_qty_q), .req_reply_q(req_reply_q),
		.input_six_function_select(sel), .multi_input_six(six), .selftest_pass_q(pass_q),
		.comm_error_q(cerr_q));
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (wr_en_q)
		begin
			wr_n++;
			last_reg = wr_reg_q;
			last_data = wr_data_q;
		end
		if (req_valid_q)
		begin
			req_n++;
			last_func = req_func_q;
			last_start = req_start_q;
			last_qty = req_qty_q;
			last_reply = req_reply_q;
		end
		if (cyc == 30000)
		begin
			bad_count++;
			summarize();
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic mbe_frame_t rd(input mbe_byte_t a, input logic [15:0] r, input logic [15:0] q);
		return {a, 8'h03, r[15:8], r[7:0], q[15:8], q[7:0]};
	endfunction
	function automatic mbe_frame_t wr(input mbe_byte_t a, input logic [15:0] r, input logic [15:0] d);
		return {a, 8'h10, r[15:8], r[7:0], 8'h00, 8'h01, 8'h02, d[15:8], d[7:0]};
	endfunction
	// Sends one frame, then compares the reply bytes and the write and request counts
	task automatic run(input mbe_frame_t f, input mbe_byte_t code, input int wr_exp, input int req_exp,
		input int err_at = -1, input int gap_at = -1, input bit bad_crc = 0);
		mbe_frame_t e;
		int w, q;
		logic [15:0] c;
		w = wr_n;
		q = req_n;
		m.got.delete();
		m.send(f, err_at, gap_at, bad_crc);
		for (int i = 0; i < 200 && m.got.size() < 5; i++)
			@(posedge clk);
		repeat (4) @(posedge clk);
		#1;
		e = {};
		if (code != 8'h00)
		begin
			e = {f[0], f[1] | 8'h80, code};
			c = m.crc16(e);
			e.push_back(c[7:0]);
			e.push_back(c[15:8]);
		end
		check(16'(m.got.size()), 16'(e.size()));
		foreach (e[i])
			if (i < m.got.size())
				check({8'h00, m.got[i]}, {8'h00, e[i]});
		check(16'(wr_n - w), 16'(wr_exp));
		check(16'(req_n - q), 16'(req_exp));
	endtask
	task automatic t_func();
		mbe_byte_t fc[7] = '{8'h01, 8'h02, 8'h05, 8'h06, 8'h0F, 8'h17, 8'h2B};
		foreach (fc[i])
		begin
			m.slow = i[0];
			run({STN, fc[i], 8'h00, 8'h01, 8'h00, 8'h01}, 8'h01, 0, 0);
		end
		m.slow = 0;
		run({STN, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 8'h00, 0, 1);
		check({8'h00, last_func}, 16'h0008);
		$display("function code test done");
	endtask
	task automatic t_reg_qty();
		run(rd(STN, 16'h0BAD, 16'h0001), 8'h02, 0, 0);
		run(wr(STN, 16'h0BAD, 16'h0001), 8'h02, 0, 0);
		run(rd(STN, 16'h0001, 16'h0000), 8'h03, 0, 0);
		run(rd(STN, 16'h0001, 16'h0011), 8'h03, 0, 0);
		run({STN, 8'h10, 8'h00, 8'h05, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02}, 8'h03, 0, 0);
		run(rd(STN, 16'h0001, 16'h0010), 8'h00, 0, 1);
		check({8'h00, last_func}, 16'h0003);
		check(last_start, 16'h0001);
		check(last_qty, 16'h0010);
		check({15'h0000, last_reply}, 16'h0001);
		$display("register and quantity test done");
	endtask
	task automatic t_write();
		logic [15:0] r[10] = '{16'h0001, 16'h0001, 16'h0030, 16'h0050, 16'h0020, 16'h0001, 16'h0900, 16'h0001,
			16'h0040, 16'h0001};
		logic [15:0] d[10] = '{16'h1000, 16'h0777, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0001,
			16'h0042, 16'h0005};
		logic [3:0] fl[10] = '{4'h0, 4'h0, 4'h8, 4'h2, 4'h0, 4'h4, 4'h4, 4'h1, 4'h2, 4'h8};
		mbe_byte_t c[10] = '{8'h21, 8'h21, 8'h22, 8'h22, 8'h22, 8'h23, 8'h23, 8'h24, 8'h00, 8'h00};
		foreach (r[i])
		begin
			{running, uv, nv, busy} = fl[i];
			run(wr(STN, r[i], d[i]), c[i], c[i] == 8'h00, c[i] == 8'h00);
			if (c[i] == 8'h00)
			begin
				check(last_reg, r[i]);
				check(last_data, d[i]);
			end
		end
		{running, uv, nv, busy} = 4'h0;
		$display("write check test done");
	endtask
	task automatic t_silent();
		run(rd(STN, 16'h0001, 16'h0001), 8'h00, 0, 0, 3);
		run(rd(STN, 16'h0001, 16'h0001), 8'h00, 0, 0, -1, -1, 1);
		run(rd(8'h22, 16'h0001, 16'h0001), 8'h00, 0, 0);
		run(rd(STN, 16'h0001, 16'h0001), 8'h00, 0, 0, -1, 4);
		// At two clocks per bit the same pause is only about 15 bit periods
		baud = 16'h0002;
		run(rd(STN, 16'h0001, 16'h0001), 8'h00, 0, 1, -1, 4);
		baud = 16'h0001;
		run({STN, 8'h03}, 8'h00, 0, 0);
		run({STN, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00}, 8'h00, 0, 0);
		run({STN, 8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h00}, 8'h00, 0, 0);
		$display("silent discard test done");
	endtask
	task automatic t_bcast();
		run(wr(8'h00, 16'h0001, 16'h0123), 8'h00, 1, 1);
		check(last_reg, 16'h0001);
		check({15'h0000, last_reply}, 16'h0000);
		run(wr(8'h00, 16'h0005, 16'h0123), 8'h00, 0, 0);
		run(rd(8'h00, 16'h0001, 16'h0001), 8'h00, 0, 0);
		run({8'h00, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05, 8'h00, 8'h06}, 8'h00, 2, 1);
		check(last_reg, 16'h0002);
		check(last_data, 16'h0006);
		$display("broadcast test done");
	endtask
	task automatic t_selftest();
		sel = 8'h43;
		six = 1;
		m.echo(400, 0);
		check({15'h0000, pass_q}, 16'h0001);
		m.echo(400, 1);
		check({15'h0000, cerr_q}, 16'h0001);
		sel = 8'h00;
		six = 0;
		repeat (300) @(posedge clk);
		check({14'h0000, pass_q, cerr_q}, 16'h0000);
		$display("self-test test done");
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		resetn = 1;
		t_func();
		t_reg_qty();
		t_write();
		t_silent();
		t_bcast();
		t_selftest();
		summarize();
	end
endmodule // mbe_slave_bench

//--- rtl/mbe_crc16.sv
// CRC-16 engine, one byte per clock, reflected polynomial.
// Assumes the user holds clear while idle; a byte given with clear starts a new sum.
`timescale 1ns/1ps
`include "mbe_defines.svh"
module mbe_crc16
	import mbe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Byte feed
	mbe_crc_if.engine bus
);
	logic [15:0] crc_q;
	logic [15:0] crc_d;
	logic [15:0] base;

	always_comb
	begin
		base = bus.clear ? `MBE_CRC_INIT : crc_q;
		crc_d = base ^ {8'h00, bus.data};
		for (int i = 0; i < 8; i++)
		begin
			crc_d = crc_d[0] ? ((crc_d >> 1) ^ `MBE_CRC_POLY) : (crc_d >> 1);
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			crc_q <= `MBE_CRC_INIT;
		else if (bus.en)
			crc_q <= crc_d;
		else if (bus.clear)
			crc_q <= `MBE_CRC_INIT;
	end

	assign bus.crc = crc_q;
endmodule // mbe_crc16

//--- rtl/mbe_crc_if.sv
// Link between a CRC-16 engine and the logic that feeds it bytes.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mbe_crc_if;
	logic clear;
	logic en;
	logic [7:0] data;
	logic [15:0] crc;
	modport user(output clear, output en, output data, input crc);
	modport engine(input clear, input en, input data, output crc);
endinterface : mbe_crc_if

//--- rtl/mbe_defines.svh
// Constants of the serial request checker: function codes, exception codes,
// frame layout and timing figures. Definitions only; included by bare name.
`ifndef MBE_DEFINES_SVH
`define MBE_DEFINES_SVH

// Function codes that the slave serves, and the exception flag
`define MBE_FC_READ 8'h03
`define MBE_FC_LOOP 8'h08
`define MBE_FC_WRITE 8'h10
`define MBE_EXC_FLAG 8'h80

// Exception codes
`define MBE_EXC_NONE 8'h00
`define MBE_EXC_FUNC 8'h01
`define MBE_EXC_REG 8'h02
`define MBE_EXC_COUNT 8'h03
`define MBE_EXC_DATA 8'h21
`define MBE_EXC_MODE 8'h22
`define MBE_EXC_UV 8'h23
`define MBE_EXC_BUSY 8'h24

// Addressing
`define MBE_BCAST_ADDR 8'h00
`define MBE_BCAST_REG_FIRST 16'h0001
`define MBE_BCAST_REG_LAST 16'h0002
`define MBE_ENTER_EEPROM_REG 16'h0900
`define MBE_ENTER_RAM_REG 16'h0910

// Frame layout, in bytes from the address byte
`define MBE_POS_ADDR 8'h00
`define MBE_POS_FUNC 8'h01
`define MBE_POS_START_HI 8'h02
`define MBE_POS_START_LO 8'h03
`define MBE_POS_QTY_HI 8'h04
`define MBE_POS_QTY_LO 8'h05
`define MBE_POS_BCNT 8'h06
`define MBE_POS_DATA 8'h07
`define MBE_MIN_LEN 8'h04
`define MBE_FIXED_LEN 8'h08
`define MBE_WR_OVERHEAD 9'h009
`define MBE_MAX_QTY 16'h0010
`define MBE_MAX_DATA_BYTES 8'h20
`define MBE_CNT_MAX 8'hFF

// Exception reply layout
`define MBE_EXC_LEN 3'h5
`define MBE_EXC_CRC_POS 3'h3

// CRC-16
`define MBE_CRC_INIT 16'hFFFF
`define MBE_CRC_POLY 16'hA001
`define MBE_CRC_GOOD 16'h0000

// Inter-character gap, in bit periods
`define MBE_GAP_BITS 5'h18
`define MBE_DIV_ONE 16'h0001

// Serial self-test
`define MBE_SELFTEST_SEL 8'h43
`define MBE_TEST_PATTERN 8'h55

`endif

//--- rtl/mbe_gap_timer.sv
// Silence timer counting bit periods since the last restart.
// Assumes baud_div holds clocks per bit and is at least one.
`timescale 1ns/1ps
`include "mbe_defines.svh"
module mbe_gap_timer
	import mbe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic restart,
	input wire logic [15:0] baud_div,
	// Status
	output logic gap_over
);
	logic [15:0] div_q;
	logic [4:0] bits_q;
	logic over_q;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_q <= 16'h0000;
			bits_q <= 5'd0;
			over_q <= 1'b1;
		end
		else if (restart)
		begin
			div_q <= 16'h0000;
			bits_q <= 5'd0;
			over_q <= 1'b0;
		end
		else if (!over_q)
		begin
			if (div_q >= baud_div - `MBE_DIV_ONE)
			begin
				div_q <= 16'h0000;
				bits_q <= bits_q + 5'd1;
				// Over only once a full 25th bit has gone silent
				over_q <= (bits_q == `MBE_GAP_BITS);
			end
			else
				div_q <= div_q + 16'h0001;
		end
	end

	assign gap_over = over_q;
endmodule // mbe_gap_timer

//--- rtl/mbe_pkg.sv
// Types shared by the serial request checker modules.
// Assumes mbe_defines.svh supplies the numeric constants.
package mbe_pkg;
	typedef enum logic [2:0] {
		MBE_IDLE = 3'b000,
		MBE_RECV = 3'b001,
		MBE_CHECK = 3'b010,
		MBE_EXEC = 3'b011,
		MBE_SEND = 3'b100,
		MBE_TEST = 3'b101
	} mbe_state_e;
	typedef logic [7:0] mbe_byte_t;
endpackage

//--- rtl/mbe_slave.sv
// Request checker of a serial RTU slave: frames, validates, answers exceptions.
// Assumes a UART on the same clock delivers bytes and line errors as pulses,
// and the parameter store answers attribute queries combinationally.
`timescale 1ns/1ps
`include "mbe_defines.svh"
module mbe_slave
	import mbe_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Received bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_err,
	input wire logic [15:0] baud_div,
	// Transmitted bytes
	output logic tx_valid_q,
	output logic [7:0] tx_data_q,
	input wire logic tx_ready,
	// Drive status
	input wire logic [7:0] station_address_setting,
	input wire logic drive_running,
	input wire logic bus_undervoltage_fault,
	input wire logic nonvolatile_data_fault,
	input wire logic param_busy,
	// Parameter store queries
	output logic [15:0] query_reg_q,
	output logic [15:0] query_data_q,
	input wire logic reg_exists,
	input wire logic reg_read_only,
	input wire logic reg_run_locked,
	input wire logic reg_init_exempt,
	input wire logic data_in_range,
	input wire logic data_consistent,
	// Accepted writes
	output logic wr_en_q,
	output logic [15:0] wr_reg_q,
	output logic [15:0] wr_data_q,
	// Accepted requests for the normal responder
	output logic req_valid_q,
	output logic [7:0] req_func_q,
	output logic [15:0] req_start_q,
	output logic [15:0] req_qty_q,
	output logic req_reply_q,
	// Self-test
	input wire logic [7:0] input_six_function_select,
	input wire logic multi_input_six,
	output logic selftest_pass_q,
	output logic comm_error_q
);
	mbe_state_e state_q;
	mbe_byte_t addr_q, func_q, bcnt_q, exc_q;
	logic [7:0] cnt_q;
	logic [15:0] start_q, qty_q;
	logic [15:0] words_q [0:15];
	logic bad_q, phase_q, pin_six_meta_q, pin_six_q;
	logic [3:0] idx_q;
	logic [2:0] txi_q;
	logic gap_over, take, tx_hs, bcast, is_write, test_mode, test_tx;
	logic [7:0] woff;
	logic ev_drop;
	mbe_byte_t ev_code, chk_code, tx_byte;
	logic [16:0] last_reg;
	mbe_crc_if rx_crc();
	mbe_crc_if tx_crc();

	// Bytes are only taken while framing; late bytes during a reply are dropped
	assign take = rx_valid && (state_q == MBE_IDLE || state_q == MBE_RECV);
	assign tx_hs = tx_valid_q && tx_ready;
	assign test_tx = (state_q == MBE_TEST) && tx_hs;
	assign bcast = (addr_q == `MBE_BCAST_ADDR);
	assign is_write = (func_q == `MBE_FC_WRITE);
	assign test_mode = (input_six_function_select == `MBE_SELFTEST_SEL) && pin_six_q;
	assign woff = cnt_q - `MBE_POS_DATA;
	assign last_reg = {1'b0, start_q} + {1'b0, qty_q} - 17'h00001;

	assign rx_crc.clear = (state_q == MBE_IDLE);
	assign rx_crc.en = take;
	assign rx_crc.data = rx_data;
	assign tx_crc.clear = (state_q != MBE_SEND);
	assign tx_crc.en = (state_q == MBE_SEND) && tx_hs && (txi_q < `MBE_EXC_CRC_POS);
	assign tx_crc.data = tx_data_q;

	mbe_crc16 u_rx_crc (.clk(clk), .resetn(resetn), .bus(rx_crc.engine));
	mbe_crc16 u_tx_crc (.clk(clk), .resetn(resetn), .bus(tx_crc.engine));

	// Gap restarts at each stop bit end, and at each test byte sent
	mbe_gap_timer u_gap (
		.clk(clk),
		.resetn(resetn),
		.restart(rx_valid || test_tx),
		.baud_div(baud_div),
		.gap_over(gap_over)
	);

	// Selector pin is asynchronous
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_six_meta_q <= 1'b0;
			pin_six_q <= 1'b0;
		end
		else
		begin
			pin_six_meta_q <= multi_input_six;
			pin_six_q <= pin_six_meta_q;
		end
	end

	// Frame verdict once the line has gone silent
	always_comb
	begin
		ev_drop = bad_q || (rx_crc.crc != `MBE_CRC_GOOD);
		if (cnt_q < `MBE_MIN_LEN)
			ev_drop = 1'b1;
		if (!bcast && addr_q != station_address_setting)
			ev_drop = 1'b1;
		if ((func_q == `MBE_FC_READ || func_q == `MBE_FC_LOOP) && cnt_q != `MBE_FIXED_LEN)
			ev_drop = 1'b1;
		if (is_write && {1'b0, cnt_q} != ({1'b0, bcnt_q} + `MBE_WR_OVERHEAD))
			ev_drop = 1'b1;
		ev_code = `MBE_EXC_NONE;
		if (func_q != `MBE_FC_READ && func_q != `MBE_FC_LOOP && !is_write)
			ev_code = `MBE_EXC_FUNC;
		else if (func_q != `MBE_FC_LOOP && (qty_q == 16'h0000 || qty_q > `MBE_MAX_QTY))
			ev_code = `MBE_EXC_COUNT;
		else if (is_write && {9'h000, bcnt_q} != {1'b0, qty_q[14:0], 1'b0})
			ev_code = `MBE_EXC_COUNT;
		else if (bcast && (!is_write || start_q < `MBE_BCAST_REG_FIRST || last_reg > {1'b0, `MBE_BCAST_REG_LAST}))
			ev_code = `MBE_EXC_REG;
	end

	// Per-register attribute check against the store's answer
	always_comb
	begin
		chk_code = `MBE_EXC_NONE;
		if (!reg_exists)
			chk_code = `MBE_EXC_REG;
		else if (is_write)
		begin
			if (param_busy)
				chk_code = `MBE_EXC_BUSY;
			else if (bus_undervoltage_fault)
				chk_code = `MBE_EXC_UV;
			else if (reg_read_only)
				chk_code = `MBE_EXC_MODE;
			else if (drive_running && reg_run_locked)
				chk_code = `MBE_EXC_MODE;
			else if (nonvolatile_data_fault && !reg_init_exempt)
				chk_code = `MBE_EXC_MODE;
			else if (!data_in_range || !data_consistent)
				chk_code = `MBE_EXC_DATA;
		end
	end

	// Byte capture
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_q <= 8'h00;
			addr_q <= 8'h00;
			func_q <= 8'h00;
			start_q <= 16'h0000;
			qty_q <= 16'h0000;
			bcnt_q <= 8'h00;
		end
		else if (take)
		begin
			cnt_q <= (state_q == MBE_IDLE) ? 8'h01 : ((cnt_q == `MBE_CNT_MAX) ? cnt_q : cnt_q + 8'h01);
			case ((state_q == MBE_IDLE) ? `MBE_POS_ADDR : cnt_q)
				`MBE_POS_ADDR: addr_q <= rx_data;
				`MBE_POS_FUNC: func_q <= rx_data;
				`MBE_POS_START_HI: start_q[15:8] <= rx_data;
				`MBE_POS_START_LO: start_q[7:0] <= rx_data;
				`MBE_POS_QTY_HI: qty_q[15:8] <= rx_data;
				`MBE_POS_QTY_LO: qty_q[7:0] <= rx_data;
				`MBE_POS_BCNT: bcnt_q <= rx_data;
				default: ;
			endcase
		end
	end

	// Write data held until the whole frame is proven good
	always_ff @(posedge clk)
	begin
		if (take && state_q == MBE_RECV && cnt_q >= `MBE_POS_DATA && woff < `MBE_MAX_DATA_BYTES)
		begin
			if (woff[0])
				words_q[woff[4:1]][7:0] <= rx_data;
			else
				words_q[woff[4:1]][15:8] <= rx_data;
		end
	end

	// Line errors spoil the whole frame
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			bad_q <= 1'b0;
		else if (state_q == MBE_IDLE)
			bad_q <= rx_err;
		else if (rx_err)
			bad_q <= 1'b1;
	end

	// Sequencer
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= MBE_IDLE;
			idx_q <= 4'h0;
			phase_q <= 1'b0;
			exc_q <= `MBE_EXC_NONE;
		end
		else
		begin
			case (state_q)
				MBE_IDLE:
				begin
					phase_q <= 1'b0;
					if (test_mode)
						state_q <= MBE_TEST;
					else if (rx_valid)
						state_q <= MBE_RECV;
				end
				MBE_RECV:
				begin
					idx_q <= 4'h0;
					phase_q <= 1'b0;
					exc_q <= ev_code;
					// A gap too long ends the frame; its length or CRC then fails
					if (gap_over)
					begin
						if (ev_drop)
							state_q <= MBE_IDLE;
						else if (ev_code != `MBE_EXC_NONE)
							state_q <= bcast ? MBE_IDLE : MBE_SEND;
						else if (func_q == `MBE_FC_LOOP)
							state_q <= MBE_EXEC;
						else
							state_q <= MBE_CHECK;
					end
				end
				MBE_CHECK:
				begin
					phase_q <= !phase_q;
					if (phase_q)
					begin
						if (chk_code != `MBE_EXC_NONE)
						begin
							exc_q <= chk_code;
							state_q <= bcast ? MBE_IDLE : MBE_SEND;
						end
						else if ({12'h000, idx_q} == qty_q - 16'h0001)
						begin
							idx_q <= 4'h0;
							state_q <= MBE_EXEC;
						end
						else
							idx_q <= idx_q + 4'h1;
					end
				end
				MBE_EXEC:
				begin
					// Writes go out one per clock, nothing is stored before all checks pass
					if (!is_write || {12'h000, idx_q} == qty_q - 16'h0001)
						state_q <= MBE_IDLE;
					else
						idx_q <= idx_q + 4'h1;
				end
				MBE_SEND:
				begin
					if (!tx_valid_q && txi_q == `MBE_EXC_LEN)
						state_q <= MBE_IDLE;
				end
				MBE_TEST:
				begin
					if (!test_mode && !tx_valid_q)
						state_q <= MBE_IDLE;
					else if (test_tx)
						phase_q <= 1'b1;
					else if (phase_q && (rx_valid || rx_err || gap_over))
						phase_q <= 1'b0;
				end
				default: state_q <= MBE_IDLE;
			endcase
		end
	end

	// Attribute queries
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			query_reg_q <= 16'h0000;
			query_data_q <= 16'h0000;
		end
		else if (state_q == MBE_CHECK && !phase_q)
		begin
			query_reg_q <= start_q + {12'h000, idx_q};
			query_data_q <= words_q[idx_q];
		end
	end

	// Write strobes and request hand-off
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_en_q <= 1'b0;
			wr_reg_q <= 16'h0000;
			wr_data_q <= 16'h0000;
			req_valid_q <= 1'b0;
			req_func_q <= 8'h00;
			req_start_q <= 16'h0000;
			req_qty_q <= 16'h0000;
			req_reply_q <= 1'b0;
		end
		else
		begin
			wr_en_q <= (state_q == MBE_EXEC) && is_write;
			wr_reg_q <= start_q + {12'h000, idx_q};
			wr_data_q <= words_q[idx_q];
			req_valid_q <= (state_q == MBE_EXEC) && (!is_write || {12'h000, idx_q} == qty_q - 16'h0001);
			req_func_q <= func_q;
			req_start_q <= start_q;
			req_qty_q <= qty_q;
			req_reply_q <= !bcast;
		end
	end

	// Exception reply bytes: address, flagged function, code, CRC low, CRC high
	always_comb
	begin
		case (txi_q)
			3'h0: tx_byte = addr_q;
			3'h1: tx_byte = func_q | `MBE_EXC_FLAG;
			3'h2: tx_byte = exc_q;
			3'h3: tx_byte = tx_crc.crc[7:0];
			default: tx_byte = tx_crc.crc[15:8];
		endcase
	end

	// Transmit side; one idle clock between bytes lets the CRC settle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
			txi_q <= 3'h0;
		end
		else if (tx_hs)
		begin
			tx_valid_q <= 1'b0;
			txi_q <= txi_q + 3'h1;
		end
		else if (!tx_valid_q)
		begin
			if (state_q == MBE_SEND && txi_q != `MBE_EXC_LEN)
			begin
				tx_valid_q <= 1'b1;
				tx_data_q <= tx_byte;
			end
			else if (state_q == MBE_TEST && test_mode && !phase_q)
			begin
				tx_valid_q <= 1'b1;
				tx_data_q <= `MBE_TEST_PATTERN;
			end
			else if (state_q != MBE_SEND)
				txi_q <= 3'h0;
		end
	end

	// Self-test result; a mismatch, line error or lost echo counts as failure
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			selftest_pass_q <= 1'b0;
			comm_error_q <= 1'b0;
		end
		else if (state_q != MBE_TEST)
		begin
			selftest_pass_q <= 1'b0;
			comm_error_q <= 1'b0;
		end
		else if (phase_q && !test_tx)
		begin
			if (rx_valid && !rx_err && rx_data == `MBE_TEST_PATTERN)
			begin
				selftest_pass_q <= 1'b1;
				comm_error_q <= 1'b0;
			end
			else if (rx_valid || rx_err || gap_over)
			begin
				selftest_pass_q <= 1'b0;
				comm_error_q <= 1'b1;
			end
		end
	end
endmodule // mbe_slave
